// ==== bdw_pkg.sv ====
/*
  bdw_pkg: register map, field positions and encodings shared by the dma dwell
  and array-order block.
  assumes: one clock domain, 32-bit ahb-lite register access, word aligned.
*/
`default_nettype none
package bdw_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00; // dma_control_reg
  localparam logic [7:0] CMD_OFS = 8'h04; // channel commands, read as zero
  localparam logic [7:0] DWELL_OFS = 8'h08; // bus_dwell_limits
  localparam logic [7:0] CHST_OFS = 8'h0c; // channel status
  localparam logic [7:0] IRQ_ST_OFS = 8'h10; // sticky events, clear on read
  localparam logic [7:0] IRQ_MSK_OFS = 8'h14; // interrupt mask
  localparam logic [7:0] ENTRY_OFS = 8'h18; // last fetched array entry address
  localparam logic [7:0] ECNT_OFS = 8'h1c; // last fetched entry count
  // ==========================================================
  // control register fields
  localparam int CTRL_BIGEND_BIT = 12; // byte order of array entries
  localparam int CTRL_BUS8_BIT = 0; // 1 = 8-bit memory bus
  localparam int CTRL_LINK_BIT = 1; // 1 = linked-array mode
  localparam logic [15:0] CTRL_IMPL = 16'h1003; // implemented bits
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // command register fields (one channel, three bits)
  localparam int CMD_EN_BIT = 0; // enable channel
  localparam int CMD_DIS_BIT = 1; // disable channel
  localparam int CMD_LOAD_BIT = 2; // base registers loaded
  // dwell register fields
  localparam int DW_XFER_LSB = 8; // transfer limit, upper byte
  localparam int DW_CYC_LSB = 0; // cycle limit, lower byte
  localparam logic [15:0] DWELL_RST = 16'h0000;
  // interrupt bits
  localparam int IRQ_RELEASE_BIT = 0; // tenure ended by dwell limit
  localparam int IRQ_CHAIN_BIT = 1; // array chain terminated
  localparam int IRQ_W = 2;
  // ==========================================================
  // channel phases
  typedef enum logic [1:0] {
    BDW_DATA_PH = 2'b00,
    BDW_ARRAY_PH = 2'b01,
    BDW_LINK_PH = 2'b10
  } bdw_phase_t;
  // fetch engine states
  typedef enum logic [2:0] {
    BDW_IDLE = 3'b000,
    BDW_REQ = 3'b001,
    BDW_OWN = 3'b010,
    BDW_WAIT = 3'b011,
    BDW_DONE = 3'b100
  } bdw_state_t;
endpackage : bdw_pkg
`default_nettype wire

// ==== bdw_dma.sv ====
/*
  bdw_dma: register file, channel status and array-entry fetch engine with
  burst dwell limits, for one dma channel of a serial controller.
  assumes: ahb-lite slave on hclk; a simple memory master port where mem_rdy
  may stretch a cycle; the arbiter answers mem_req with mem_gnt.
*/
// The register addresses and the AHB-Lite slave port are this design's own decisions.
// ==========================================================
// Overview of operation
// RL1 - control bits change only on processor writes
// RL2 - command bits act when written, read zero
// RL3 - status bits ignore processor writes
// RL4 - command/status bits writable and set by hardware
// RL5 - implemented reserved bits store, others read zero
// RL6 - software writes zeros to reserved bits
// RL7 - status shows enabled and base valid
// RL8 - status shows data or array phase
// RL9 - linked mode shows link phase; no impossible codes
// RL10 - control bit 12 selects entry byte order
// RL11 - 16-bit bus: big end high word first
// RL12 - 8-bit bus: big end msb byte first
// RL13 - dwell upper byte limits transfers per tenure
// RL14 - zero transfer limit means unlimited
// RL15 - dwell lower byte limits cycles per tenure
// RL16 - running bus cycle always completes
// RL17 - limit reached: release bus, re-request later
// RL18 - counters restart each tenure; nonzero enables cycle limit
// RL19 - entry is address then count; zero count ends
`timescale 1ns/1ps
`default_nettype none
module bdw_dma (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_req,
  input wire logic mem_gnt,
  output logic mem_cyc,
  output logic [31:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_rdy,
  output logic irq
);
  // ==========================================================
  // register state
  logic [15:0] ctrl_r; // dma control
  logic [15:0] dwell_r; // bus dwell limits
  // width taken from the package so map and logic cannot drift
  localparam int IRQ_W_L = bdw_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_st_r; // sticky events
  logic [IRQ_W_L-1:0] irq_msk_r; // interrupt mask
  logic ch_en_r; // channel enabled
  logic base_ok_r; // base registers valid
  bdw_pkg::bdw_phase_t phase_r; // transfer phase
  bdw_pkg::bdw_state_t st_r; // fetch engine state
  logic [31:0] base_r; // array pointer
  logic [31:0] ent_addr_r; // assembled entry address
  logic [15:0] ent_cnt_r; // assembled entry count
  logic [2:0] pos_r; // unit index within entry
  logic [7:0] xfer_cnt_r; // transfers this tenure
  logic [7:0] cyc_cnt_r; // cycles this tenure
  // ahb address phase capture
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] ofs_r;
  logic ap_take;
  assign ap_take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay
  // ==========================================================
  // capture address phase
  // only word transfers are expected; hsize is not checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ofs_r <= 8'h00;
    end else begin
      wr_pend_r <= ap_take && hwrite;
      rd_pend_r <= ap_take && !hwrite;
      if (ap_take) begin
        ofs_r <= haddr[7:0];
      end
    end
  end
  // data phase strobes; hwdata is valid one cycle after the address
  logic wr_ctrl, wr_cmd, wr_dwell, wr_msk, rd_irq;
  assign wr_ctrl = wr_pend_r && (ofs_r == bdw_pkg::CTRL_OFS);
  assign wr_cmd = wr_pend_r && (ofs_r == bdw_pkg::CMD_OFS);
  assign wr_dwell = wr_pend_r && (ofs_r == bdw_pkg::DWELL_OFS);
  assign wr_msk = wr_pend_r && (ofs_r == bdw_pkg::IRQ_MSK_OFS);
  assign rd_irq = rd_pend_r && (ofs_r == bdw_pkg::IRQ_ST_OFS);
  // ==========================================================
  // control and dwell: only software changes them
  // unimplemented control bits are masked so they read back zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= bdw_pkg::CTRL_RST;
      dwell_r <= bdw_pkg::DWELL_RST;
      irq_msk_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[15:0] & bdw_pkg::CTRL_IMPL; // RL1 RL5
      end
      if (wr_dwell) begin
        dwell_r <= hwdata[15:0]; // RL13 RL15
      end
      if (wr_msk) begin
        irq_msk_r <= hwdata[IRQ_W_L-1:0];
      end
    end
  end
  // ==========================================================
  // fetch engine signals
  // one entry is three halfwords or six bytes
  logic ent_last; // last unit of the entry
  logic unit_done; // a memory cycle completes
  logic limit_hit; // dwell limit reached
  logic chain_end; // zero count fetched
  logic bus8;
  logic bigend;
  logic [7:0] xfer_lim;
  logic [7:0] cyc_lim;
  logic [8:0] xfer_sum; // transfers including the completing one
  logic [8:0] cyc_sum; // cycles including the current one
  logic [31:0] addr_next; // entry address after this unit
  logic [15:0] ent_cnt_next; // entry count after this unit
  assign bus8 = ctrl_r[bdw_pkg::CTRL_BUS8_BIT];
  assign bigend = ctrl_r[bdw_pkg::CTRL_BIGEND_BIT]; // RL10
  assign xfer_lim = dwell_r[bdw_pkg::DW_XFER_LSB +: 8];
  assign cyc_lim = dwell_r[bdw_pkg::DW_CYC_LSB +: 8];
  assign unit_done = (st_r == bdw_pkg::BDW_WAIT) && mem_rdy;
  assign ent_last = bus8 ? (pos_r == 3'd5) : (pos_r == 3'd2); // RL19
  // limit counted after the completing transfer; nine bits so a
  // saturated cycle count cannot wrap below the limit
  assign xfer_sum = {1'b0, xfer_cnt_r} + 9'd1;
  assign cyc_sum = {1'b0, cyc_cnt_r} + 9'd1;
  assign limit_hit = ((xfer_lim != 8'h00) && (xfer_sum >= {1'b0, xfer_lim})) // RL14
    || ((cyc_lim != 8'h00) && (cyc_sum >= {1'b0, cyc_lim})); // RL18
  assign chain_end = unit_done && ent_last && (ent_cnt_next == 16'h0000);
  // ==========================================================
  // byte/word placement of the fetched unit; only latched on ready,
  // so the value between cycles does not matter
  always_comb begin
    addr_next = ent_addr_r;
    ent_cnt_next = ent_cnt_r;
    if (bus8) begin
      // RL12 big end: msb byte at lowest address
      case (pos_r)
        3'd0: if (bigend) addr_next[31:24] = mem_rdata[7:0];
          else addr_next[7:0] = mem_rdata[7:0];
        3'd1: if (bigend) addr_next[23:16] = mem_rdata[7:0];
          else addr_next[15:8] = mem_rdata[7:0];
        3'd2: if (bigend) addr_next[15:8] = mem_rdata[7:0];
          else addr_next[23:16] = mem_rdata[7:0];
        3'd3: if (bigend) addr_next[7:0] = mem_rdata[7:0];
          else addr_next[31:24] = mem_rdata[7:0];
        // RL10 the count follows the same byte order as the address
        3'd4: if (bigend) ent_cnt_next[15:8] = mem_rdata[7:0];
          else ent_cnt_next[7:0] = mem_rdata[7:0];
        default: if (bigend) ent_cnt_next[7:0] = mem_rdata[7:0];
          else ent_cnt_next[15:8] = mem_rdata[7:0];
      endcase
    end else begin
      // RL11 big end: bits 31..16 at word n
      case (pos_r)
        3'd0: if (bigend) addr_next[31:16] = mem_rdata;
          else addr_next[15:0] = mem_rdata;
        3'd1: if (bigend) addr_next[15:0] = mem_rdata;
          else addr_next[31:16] = mem_rdata;
        default: ent_cnt_next = mem_rdata;
      endcase
    end
  end
  // ==========================================================
  // bus tenure state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= bdw_pkg::BDW_IDLE;
      pos_r <= 3'd0;
      base_r <= 32'h0000_0000;
      ent_addr_r <= 32'h0000_0000;
      ent_cnt_r <= 16'h0000;
      xfer_cnt_r <= 8'h00;
      cyc_cnt_r <= 8'h00;
    end else begin
      case (st_r)
        bdw_pkg::BDW_IDLE: begin
          if (ch_en_r && base_ok_r && (phase_r != bdw_pkg::BDW_DATA_PH)) begin
            st_r <= bdw_pkg::BDW_REQ;
          end
        end
        bdw_pkg::BDW_REQ: begin
          xfer_cnt_r <= 8'h00; // RL18
          cyc_cnt_r <= 8'h00; // RL18
          if (!ch_en_r) begin
            st_r <= bdw_pkg::BDW_IDLE;
          end else if (mem_gnt) begin
            st_r <= bdw_pkg::BDW_WAIT;
          end
        end
        bdw_pkg::BDW_OWN: begin
          // saturate: a long stretched cycle must not wrap the count
          if (cyc_cnt_r != 8'hff) begin
            cyc_cnt_r <= cyc_cnt_r + 8'd1;
          end
          st_r <= bdw_pkg::BDW_WAIT;
        end
        bdw_pkg::BDW_WAIT: begin
          if (cyc_cnt_r != 8'hff) begin
            cyc_cnt_r <= cyc_cnt_r + 8'd1; // RL15
          end
          // cycle stays open until ready, even past the limit
          if (mem_rdy) begin // RL16
            xfer_cnt_r <= xfer_cnt_r + 8'd1;
            ent_addr_r <= addr_next;
            ent_cnt_r <= ent_cnt_next;
            base_r <= base_r + (bus8 ? 32'd1 : 32'd2);
            if (ent_last) begin
              pos_r <= 3'd0;
            end else begin
              pos_r <= pos_r + 3'd1;
            end
            if (chain_end) begin
              st_r <= bdw_pkg::BDW_DONE;
            end else if (ent_last || !ch_en_r) begin
              st_r <= bdw_pkg::BDW_IDLE;
            end else if (limit_hit) begin
              // drop the request for a cycle so the arbiter sees a real
              // release; idle re-requests while base and phase allow it
              st_r <= bdw_pkg::BDW_IDLE; // RL17
            end else begin
              st_r <= bdw_pkg::BDW_OWN;
            end
          end
        end
        default: begin
          st_r <= bdw_pkg::BDW_IDLE;
        end
      endcase
    end
  end
  // mem_req high while asking, released at tenure end; the idle
  // cycle between tenures is what lets another master in
  assign mem_req = (st_r == bdw_pkg::BDW_REQ) || (st_r == bdw_pkg::BDW_OWN)
    || (st_r == bdw_pkg::BDW_WAIT); // RL17
  assign mem_cyc = (st_r == bdw_pkg::BDW_WAIT);
  assign mem_addr = base_r;
  // ==========================================================
  // channel status: enable, base valid, phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch_en_r <= 1'b0;
      base_ok_r <= 1'b0;
      phase_r <= bdw_pkg::BDW_DATA_PH;
    end else begin
      if (wr_cmd && hwdata[bdw_pkg::CMD_EN_BIT]) begin
        ch_en_r <= 1'b1; // RL2 RL7
        phase_r <= ctrl_r[bdw_pkg::CTRL_LINK_BIT] ? bdw_pkg::BDW_LINK_PH
          : bdw_pkg::BDW_ARRAY_PH; // RL9
      end else if (wr_cmd && hwdata[bdw_pkg::CMD_DIS_BIT]) begin
        ch_en_r <= 1'b0; // RL2
      end
      // array done: channel enters data phase, base consumed; this
      // beats a load in the same cycle, software must reload after
      if (st_r == bdw_pkg::BDW_DONE) begin
        phase_r <= bdw_pkg::BDW_DATA_PH; // RL8
        base_ok_r <= 1'b0; // RL4
      end else if (wr_cmd && hwdata[bdw_pkg::CMD_LOAD_BIT]) begin
        base_ok_r <= 1'b1; // RL4
      end
    end
  end
  // ==========================================================
  // sticky interrupt status; set beats read-clear
  logic [IRQ_W_L-1:0] irq_set;
  // clear only what the read returned: an event landing on the address
  // phase edge is missed by hrdata and must survive the clear
  logic [IRQ_W_L-1:0] irq_clr;
  assign irq_clr = rd_irq ? hrdata[IRQ_W_L-1:0] : '0;
  assign irq_set[bdw_pkg::IRQ_RELEASE_BIT] = unit_done && limit_hit && !ent_last;
  assign irq_set[bdw_pkg::IRQ_CHAIN_BIT] = chain_end;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set; // RL3
    end
  end
  assign irq = |(irq_st_r & irq_msk_r);
  // ==========================================================
  // read mux; commands and unused bits read zero
  // limitation: sampled at the address phase, so a read right behind
  // a write to the same register returns the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      if (haddr[7:0] == bdw_pkg::CTRL_OFS) begin
        hrdata <= {16'h0000, ctrl_r}; // RL1
      end else if (haddr[7:0] == bdw_pkg::DWELL_OFS) begin
        hrdata <= {16'h0000, dwell_r};
      end else if (haddr[7:0] == bdw_pkg::CHST_OFS) begin
        hrdata <= {28'h0, phase_r, base_ok_r, ch_en_r}; // RL7 RL8
      end else if (haddr[7:0] == bdw_pkg::IRQ_ST_OFS) begin
        hrdata <= {30'h0, irq_st_r};
      end else if (haddr[7:0] == bdw_pkg::IRQ_MSK_OFS) begin
        hrdata <= {30'h0, irq_msk_r};
      end else if (haddr[7:0] == bdw_pkg::ENTRY_OFS) begin
        hrdata <= ent_addr_r;
      end else if (haddr[7:0] == bdw_pkg::ECNT_OFS) begin
        hrdata <= {16'h0000, ent_cnt_r};
      end else begin
        hrdata <= 32'h0000_0000; // command and unmapped read zero
      end
    end
  end
  // ==========================================================
  // checks
  chst_legal_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
    phase_r != 2'b11) else $error("illegal phase code");
  ctrl_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
    !wr_ctrl |=> $stable(ctrl_r)) else $error("control changed alone");
  cyc_complete_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
    mem_cyc && !mem_rdy |=> mem_cyc) else $error("cycle cut short");
  // a release must be visible as a dropped request
  limit_release_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL17
    unit_done && limit_hit && !ent_last && !chain_end && ch_en_r
    |=> st_r == bdw_pkg::BDW_IDLE && !mem_req) else $error("no release on limit");
  tenure_reset_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL18
    st_r == bdw_pkg::BDW_REQ |=> cyc_cnt_r == 8'h00) else $error("count kept");
  nolimit_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL14
    dwell_r == 16'h0000 |-> !limit_hit) else $error("limit while zero");
  chain_stop_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL19
    chain_end |=> ##1 phase_r == bdw_pkg::BDW_DATA_PH) else $error("chain not ended");
  ctrl_impl_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
    (ctrl_r & ~bdw_pkg::CTRL_IMPL) == 16'h0000) else $error("absent bit set");
  // command positions hold no storage, so their data phase shows zero
  cmd_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
    rd_pend_r && (ofs_r == bdw_pkg::CMD_OFS) |-> hrdata == 32'h0000_0000)
    else $error("command read nonzero");
  // status has no write path; only events and the read clear move it
  irq_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
    !rd_irq && (irq_set == '0) |=> $stable(irq_st_r)) else $error("status written");
  // an event stays latched until software reads it
  irq_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    irq_st_r[bdw_pkg::IRQ_CHAIN_BIT] && !rd_irq |=> irq_st_r[bdw_pkg::IRQ_CHAIN_BIT])
    else $error("event lost");
  // array end clears the valid flag; software must load it again
  base_used_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    st_r == bdw_pkg::BDW_DONE |=> !base_ok_r) else $error("base still valid");
  // no fetch starts without valid base registers
  base_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
    st_r == bdw_pkg::BDW_IDLE && !base_ok_r |=> st_r == bdw_pkg::BDW_IDLE)
    else $error("fetch without base");
  // a cycle left open past its limit still releases at its end
  cyc_limit_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
    unit_done && (cyc_lim != 8'h00) && (cyc_cnt_r >= cyc_lim) && !ent_last && ch_en_r
    |=> !mem_req) else $error("cycle limit ignored");
  // within a tenure the transfer count never passes a nonzero limit
  xfer_cap_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
    mem_cyc && (xfer_lim != 8'h00) |-> xfer_cnt_r < xfer_lim)
    else $error("too many transfers");
  // units of one entry are taken strictly in memory order
  unit_order_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL19
    unit_done && !ent_last |=> pos_r == $past(pos_r) + 3'd1) else $error("unit skipped");
endmodule // bdw_dma
`default_nettype wire

// ==== bdw_mem_model.sv ====
/*
  bdw_mem_model: behavioural memory and bus arbiter facing the fetch port of
  bdw_dma; byte image loaded by the bench, wait states set per test.
  assumes: one clock, memory addressed by the low eight address bits.
*/
`timescale 1ns/1ps
`default_nettype none
module bdw_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire logic mem_cyc,
  input wire logic [31:0] mem_addr,
  input wire logic stall,
  input wire logic bus8,
  input wire logic [3:0] wait_n,
  output logic mem_gnt,
  output logic mem_rdy,
  output logic [15:0] mem_rdata
);
  // ==========================================================
  // storage and cycle state
  logic [7:0] bytes [0:255]; // byte image, written by the bench
  logic [3:0] wait_r; // wait states spent in the running cycle
  logic [15:0] last_r; // last word handed out
  logic [7:0] a_even; // even byte of the addressed halfword
  // grant follows request a cycle late; stall holds the bus off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_gnt <= 1'b0;
    end else begin
      mem_gnt <= mem_req & ~stall;
    end
  end
  // ready pulses once after wait_n stretched cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_r <= 4'h0;
      mem_rdy <= 1'b0;
    end else if (!mem_cyc || mem_rdy) begin
      wait_r <= 4'h0;
      mem_rdy <= 1'b0;
    end else if (wait_r == wait_n) begin
      mem_rdy <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
  // data only valid with ready; otherwise the inverse of the last word,
  // so a device that samples early never sees a lucky match
  always_ff @(posedge hclk) begin
    if (mem_rdy) begin
      last_r <= mem_rdata;
    end
  end
  assign a_even = {mem_addr[7:1], 1'b0};
  always_comb begin
    if (!mem_rdy) begin
      mem_rdata = ~last_r;
    end else if (bus8) begin
      mem_rdata = {~bytes[mem_addr[7:0]], bytes[mem_addr[7:0]]};
    end else begin
      mem_rdata = {bytes[a_even], bytes[a_even + 8'h01]};
    end
  end
endmodule // bdw_mem_model
`default_nettype wire

// ==== testbench.sv ====
/*
  testbench: register checks, then one array fetch per bus width and byte
  order with dwell limits, stalls and interrupts; self-checking.
  assumes: bdw_pkg, bdw_dma and bdw_mem_model compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define BDW_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
  // ==========================================================
  // signals and tables
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, stall, bus8;
  logic [31:0] haddr, hwdata, hrdata, mem_addr, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] wait_n;
  logic mem_req, mem_gnt, mem_cyc, mem_rdy, prev_cyc, prev_rdy;
  logic [15:0] mem_rdata;
  int miscompares, comparisons, units;
  typedef struct packed {logic [15:0] ctrl; logic [15:0] dwell; logic [1:0] msk;
    logic [3:0] wt; logic [1:0] st;} bdw_mode_t;
  typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] ex;} bdw_reg_t;
  bdw_mode_t modes [4];
  bdw_reg_t regs [6];
  assign hready = hreadyout; // single slave drives hready
  always #2.5 hclk = ~hclk;
  bdw_dma bdw_dma_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
    .mem_gnt(mem_gnt), .mem_cyc(mem_cyc), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_rdy(mem_rdy), .irq(irq));
  bdw_mem_model bdw_mem_model_i (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_cyc(mem_cyc), .mem_addr(mem_addr), .stall(stall), .bus8(bus8), .wait_n(wait_n),
    .mem_gnt(mem_gnt), .mem_rdy(mem_rdy), .mem_rdata(mem_rdata));
  // ==========================================================
  // fetch monitor: unit count, and no cycle may end without ready
  always @(posedge hclk) begin
    if (mem_cyc && mem_rdy) units++;
    if (hresetn && prev_cyc && !mem_cyc) `BDW_CHK("cyc_done", 1'b1, prev_rdy)
    prev_cyc = mem_cyc;
    prev_rdy = mem_rdy;
  end
  // ==========================================================
  // bus tasks; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 100) begin @(posedge hclk); n++; end
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 200) begin @(posedge hclk); n++; end
    rd = hrdata;
    if (n >= 100) miscompares++;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    ahb(1'b0, a, 32'h0);
    `BDW_CHK(nm, ex, rd)
  endtask
  task automatic pulse_reset(input int n);
    hresetn <= 1'b0;
    repeat (n) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  // ==========================================================
  // one array fetch: entry 0x12345678 / 0x0010, then a zero-count dummy
  task automatic run_mode(input bdw_mode_t m);
    logic [47:0] img;
    int u0, n, upe;
    pulse_reset(2);
    if (m.ctrl[12]) img = {32'h12345678, 16'h0010};
    else if (!m.ctrl[0]) img = {16'h5678, 16'h1234, 16'h0010};
    else img = {32'h78563412, 16'h1000};
    for (int k = 0; k < 256; k++) bdw_mem_model_i.bytes[k] = (k < 6) ? img[47-8*k -: 8] :
      (k < 10) ? 8'ha5 : (k < 12) ? 8'h00 : 8'h5a;
    upe = m.ctrl[0] ? 6 : 3;
    bus8 <= m.ctrl[0]; wait_n <= m.wt; stall <= 1'b0; u0 = units;
    ahb(1'b1, bdw_pkg::CTRL_OFS, {16'h0, m.ctrl});
    ahb(1'b1, bdw_pkg::DWELL_OFS, {16'h0, m.dwell});
    ahb(1'b1, bdw_pkg::IRQ_MSK_OFS, {30'h0, m.msk});
    ahb(1'b1, bdw_pkg::CMD_OFS, 32'h4);
    chk_rd("chst_loaded", bdw_pkg::CHST_OFS, 32'h2);
    chk_rd("cmd_zero", bdw_pkg::CMD_OFS, 32'h0);
    ahb(1'b1, bdw_pkg::CMD_OFS, 32'h1);
    n = 0;
    do begin @(negedge hclk); n++; end while (!((units - u0) >= upe && !mem_req) && n < 2000);
    if (n >= 2000) miscompares++;
    @(posedge hclk);
    stall <= 1'b1;
    chk_rd("chst_busy", bdw_pkg::CHST_OFS, m.ctrl[1] ? 32'hb : 32'h7);
    chk_rd("entry", bdw_pkg::ENTRY_OFS, 32'h12345678);
    chk_rd("ecnt", bdw_pkg::ECNT_OFS, 32'h10);
    stall <= 1'b0;
    n = 0;
    chk_rd("unmapped", 8'h20, 32'h0);
    n = 0;
    do begin ahb(1'b0, bdw_pkg::CHST_OFS, 32'h0); n++; end while (rd[3:2] != 2'b00 && n < 500);
    `BDW_CHK("chst_end", 32'h1, rd)
    @(negedge hclk);
    `BDW_CHK("irq_set", |(m.st & m.msk), irq)
    @(posedge hclk);
    chk_rd("irq_st", bdw_pkg::IRQ_ST_OFS, {30'h0, m.st});
    repeat (2) @(negedge hclk);
    `BDW_CHK("irq_clr", 1'b0, irq)
    @(posedge hclk);
    ahb(1'b1, bdw_pkg::CMD_OFS, 32'h2);
    chk_rd("chst_off", bdw_pkg::CHST_OFS, 32'h0);
  endtask
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // watchdog: whole run needs well under 20000 cycles
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; stall = 1'b0; bus8 = 1'b0; wait_n = 4'h0;
    miscompares = 0; comparisons = 0; units = 0; prev_cyc = 1'b0; prev_rdy = 1'b0;
    regs = '{'{bdw_pkg::CTRL_OFS, 32'hffffffff, {16'h0, bdw_pkg::CTRL_IMPL}},
      '{bdw_pkg::DWELL_OFS, 32'h1234abcd, 32'habcd}, '{bdw_pkg::CHST_OFS, 32'hffffffff, 32'h0},
      '{bdw_pkg::IRQ_MSK_OFS, 32'hffffffff, 32'h3}, '{bdw_pkg::IRQ_ST_OFS, 32'hffffffff, 32'h0},
      '{8'h40, 32'hffffffff, 32'h0}};
    // dwell rows: unlimited, one transfer, two cycles against three waits
    modes = '{'{16'h1000, 16'h0000, 2'h3, 4'h0, 2'h2}, '{16'h0000, 16'h0100, 2'h3, 4'h1, 2'h3},
      '{16'h1001, 16'h0002, 2'h1, 4'h3, 2'h3}, '{16'h0003, 16'h0000, 2'h1, 4'h2, 2'h2}};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_rd("ctrl_rst", bdw_pkg::CTRL_OFS, {16'h0, bdw_pkg::CTRL_RST});
    chk_rd("dwell_rst", bdw_pkg::DWELL_OFS, {16'h0, bdw_pkg::DWELL_RST});
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, regs[i].a, regs[i].wd);
      chk_rd("reg", regs[i].a, regs[i].ex);
    end
    @(negedge hclk);
    `BDW_CHK("irq_idle", 1'b0, irq)
    @(posedge hclk);
    for (int i = 0; i < 4; i++) run_mode(modes[i]);
    conclude();
  end
endmodule // testbench
`default_nettype wire
